// ### shared/cis_conv_map.vh
// Constants of the pixel conversion control block.
// Assumes inclusion by bare name from the rtl files.
`ifndef CIS_CONV_MAP_VH
`define CIS_CONV_MAP_VH
// Control word bit positions
`define CFG_ROT_LO_BIT 0
`define CFG_ROT_HI_BIT 1
`define CFG_AC_BIT 2
`define CFG_EXTREF_BIT 3
`define CFG_INTREF_BIT 4
`define CFG_INVERT_BIT 5
`define CFG_RESET 8'h00
// Register indices on the command port
`define REG_CFG 4'h0
`define REG_GAIN0 4'h1
`define REG_GAIN1 4'h2
`define REG_GAIN2 4'h3
`define REG_OFS0 4'h4
`define REG_OFS1 4'h5
`define REG_OFS2 4'h6
`define REG_STATUS 4'h7
`define REG_GAIN_DIRECT 4'h8
`define REG_OFS_DIRECT 4'h9
`define GAIN_RESET 6'h00
`define OFS_RESET 8'h00
// Pipeline latency in conversion-clock cycles
`define LATENCY 8
`define COLOURS 3
`define FIFO_DEPTH 32
`endif

// ### rtl/conv_fifo.v
// Parameterised FIFO, flip-flop storage, valid/ready on both sides.
// Assumes one clock and asynchronous active-low reset.
module conv_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rd_r];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= {AW{1'b0}};
            rd_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) wr_r <= wr_r + 1'b1;
            if (pop) rd_r <= rd_r + 1'b1;
            if (push && !pop) cnt_r <= cnt_r + 1'b1;
            else if (pop && !push) cnt_r <= cnt_r - 1'b1;
        end
    end
    always @(posedge clk) begin
        if (push) mem_r[wr_r] <= in_data;
    end
endmodule // conv_fifo

// ### rtl/cis_pixel_conversion_control.v
// Digital control of a linear sensor signal processor: pixel timing, byte bus, clamp, modes.
// Assumes conversion_clock, clamp, line_sync and the converter result are synchronous to clk.
`include "cis_conv_map.vh"
module cis_pixel_conversion_control (
    input wire clk,
    input wire rst_n,
    // Command port
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata,
    // Timing strobes from scanner controller
    input wire conversion_clock,
    input wire clamp,
    input wire line_sync,
    // Converter interface
    input wire [15:0] adc_result,
    output reg adc_sample_r,
    output reg adc_track_r,
    output reg pga_track_next_r,
    output reg clamp_switch_r,
    output reg ext_ref_subtract_r,
    output reg [7:0] offset_dac_r,
    output reg [5:0] pga_gain_r,
    output reg result_invert_r,
    output reg ref_out_enable_r,
    // Shared byte bus pins
    output reg [7:0] db_out_r,
    output reg db_oe_n_r,
    input wire [7:0] db_in,
    output reg serial_enable_r
);
    // ********************************
    // Reset release
    // ********************************
    reg rst_s1_r;
    reg rst_s2_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    wire srst_n = rst_s2_r;

    // ********************************
    // Control registers
    // ********************************
    reg [7:0] cfg_r;
    reg [5:0] gain_r [0:2];
    reg [7:0] ofs_r [0:2];
    reg [5:0] gain_direct_r;
    reg [7:0] ofs_direct_r;
    reg [1:0] colour_r;
    reg [1:0] colour_nxt;
    integer i;

    wire rotate_cfg_bit_lo = cfg_r[`CFG_ROT_LO_BIT];
    wire rotate_cfg_bit_hi = cfg_r[`CFG_ROT_HI_BIT];
    wire rotating = rotate_cfg_bit_lo && rotate_cfg_bit_hi;
    wire ac_mode = cfg_r[`CFG_AC_BIT];
    wire ext_ref_mode = cfg_r[`CFG_EXTREF_BIT];
    wire internal_ref_select_bit = cfg_r[`CFG_INTREF_BIT];

    // Per-colour slot index for a write address, 2'd3 when none
    function [1:0] slot_of;
        input [3:0] a;
        input [3:0] base;
        begin
            if (a == base) slot_of = 2'd0;
            else if (a == base + 4'h1) slot_of = 2'd1;
            else if (a == base + 4'h2) slot_of = 2'd2;
            else slot_of = 2'd3;
        end
    endfunction

    wire [1:0] gslot = slot_of(addr, `REG_GAIN0);
    wire [1:0] oslot = slot_of(addr, `REG_OFS0);

    // ********************************
    // Strobe edge detection
    // ********************************
    reg cc_d_r;
    reg sync_d_r;
    wire cc_fall = cc_d_r && !conversion_clock;
    wire cc_rise = !cc_d_r && conversion_clock;
    wire sync_fall = sync_d_r && !line_sync;

    always @* begin
        colour_nxt = colour_r;
        if (sync_fall) begin
            if (colour_r == 2'd2) colour_nxt = 2'd0;
            else colour_nxt = colour_r + 2'd1;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= `CFG_RESET;
            gain_direct_r <= `GAIN_RESET;
            ofs_direct_r <= `OFS_RESET;
            for (i = 0; i < `COLOURS; i = i + 1) begin
                gain_r[i] <= `GAIN_RESET;
                ofs_r[i] <= `OFS_RESET;
            end
            colour_r <= 2'd0;
            cc_d_r <= 1'b0;
            sync_d_r <= 1'b0;
        end else if (!srst_n) begin
            cfg_r <= `CFG_RESET;
            colour_r <= 2'd0;
            cc_d_r <= 1'b0;
            sync_d_r <= 1'b0;
        end else begin
            cc_d_r <= conversion_clock;
            sync_d_r <= line_sync;
            if (wr_en) begin
                if (addr == `REG_CFG) cfg_r <= wdata;
                else if (gslot != 2'd3) gain_r[gslot] <= wdata[5:0];
                else if (oslot != 2'd3) ofs_r[oslot] <= wdata;
                else if (addr == `REG_GAIN_DIRECT) gain_direct_r <= wdata[5:0];
                else if (addr == `REG_OFS_DIRECT) ofs_direct_r <= wdata;
            end
            // Colour held at first slot outside rotation; line sync only steps it
            if (!rotating) colour_r <= 2'd0;
            else colour_r <= colour_nxt;
        end
    end

    // ********************************
    // Register read-back
    // ********************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            if (addr == `REG_CFG) rdata <= cfg_r;
            else if (gslot != 2'd3) rdata <= {2'b00, gain_r[gslot]};
            else if (oslot != 2'd3) rdata <= ofs_r[oslot];
            else if (addr == `REG_STATUS) rdata <= {3'b000, line_sync, clamp_switch_r, rotating, colour_r};
            else if (addr == `REG_GAIN_DIRECT) rdata <= {2'b00, gain_direct_r};
            else if (addr == `REG_OFS_DIRECT) rdata <= ofs_direct_r;
            else rdata <= 8'h00;
        end else begin
            rdata <= 8'h00;
        end
    end

    // ********************************
    // Analog control
    // ********************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_sample_r <= 1'b0;
            adc_track_r <= 1'b0;
            pga_track_next_r <= 1'b0;
            clamp_switch_r <= 1'b0;
            ext_ref_subtract_r <= 1'b0;
            offset_dac_r <= `OFS_RESET;
            pga_gain_r <= `GAIN_RESET;
            result_invert_r <= 1'b0;
            ref_out_enable_r <= 1'b0;
        end else begin
            adc_sample_r <= cc_fall;
            pga_track_next_r <= cc_fall;
            adc_track_r <= conversion_clock;
            clamp_switch_r <= ac_mode && clamp;
            ext_ref_subtract_r <= ext_ref_mode && !internal_ref_select_bit;
            ref_out_enable_r <= internal_ref_select_bit;
            // Offset stays in force with external reference
            offset_dac_r <= rotating ? ofs_r[colour_r] : ofs_direct_r;
            pga_gain_r <= rotating ? gain_r[colour_r] : gain_direct_r;
            // Inverted only in AC mode with the invert bit set, so zero input reads zero code in DC mode
            result_invert_r <= ac_mode && cfg_r[`CFG_INVERT_BIT];
        end
    end

    // ********************************
    // Result pipeline and byte bus
    // ********************************
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [15:0] fifo_out;
    reg [3:0] fill_r;
    reg [15:0] word_r;
    // Entry per sample; pop once latency is reached so depth stays LATENCY
    wire pop = cc_fall && (fill_r == `LATENCY) && fifo_out_valid;

    conv_fifo #(.WIDTH(16), .DEPTH(`FIFO_DEPTH), .AW(5)) u_fifo (
        .clk(clk),
        .rst_n(srst_n),
        .in_valid(cc_fall),
        .in_ready(fifo_in_ready),
        .in_data(adc_result),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out)
    );

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_r <= 4'd0;
            word_r <= 16'h0000;
            db_out_r <= 8'h00;
            db_oe_n_r <= 1'b1;
            serial_enable_r <= 1'b0;
        end else if (!srst_n) begin
            fill_r <= 4'd0;
            db_oe_n_r <= 1'b1;
        end else begin
            if (cc_fall && fifo_in_ready && fill_r != `LATENCY) fill_r <= fill_r + 4'd1;
            if (pop) begin
                word_r <= fifo_out;
                db_out_r <= fifo_out[15:8];
            end else if (cc_rise) begin
                db_out_r <= word_r[7:0];
            end
            db_oe_n_r <= line_sync;
            serial_enable_r <= line_sync;
        end
    end
endmodule // cis_pixel_conversion_control

// ### verif/scanner_ctrl_model.sv
// Scanner controller model: conversion clock, pixel source, bus rebuild.
// Assumes the device's registered bus timing and a single clk domain.
module scanner_ctrl_model (
    input wire logic clk,
    input wire logic run,
    input wire logic line_sync,
    input wire logic adc_sample_r,
    input wire logic adc_track_r,
    input wire logic [7:0] db_out_r,
    output logic conversion_clock,
    output logic [15:0] adc_result,
    output logic [7:0] db_in,
    output logic [15:0] word,
    output logic [7:0] word_n,
    output logic word_stb
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph_r;
    logic [7:0] k_r, n_r, hi_r;
    logic trk_r;
    initial begin
        {conversion_clock, ph_r, trk_r, word_stb} = '0;
        {adc_result, db_in, word, word_n, n_r, hi_r} = '0;
        // First low phase is not a seen fall, so pixel 1 is the first pushed
        k_r = 8'h00;
    end
    always @(posedge clk) begin
        trk_r <= adc_track_r;
        word_stb <= 1'b0;
        db_in <= line_sync ? 8'h7f : ~db_out_r;
        // Clock stands still between runs
        if (run) begin
            ph_r <= ph_r + 2'd1;
            if (ph_r == 2'd1) begin
                conversion_clock <= 1'b0;
                adc_result <= {k_r ^ 8'h5a, k_r};
                k_r <= k_r + 8'h01;
            end else if (ph_r == 2'd2) begin
                // Stale pixel data does not linger
                adc_result <= ~adc_result;
            end else if (ph_r == 2'd3) begin
                conversion_clock <= 1'b1;
            end
        end
        if (adc_sample_r) begin
            hi_r <= db_out_r;
            n_r <= n_r + 8'h01;
        end
        if (adc_track_r && !trk_r) begin
            word <= {hi_r, db_out_r};
            word_n <= n_r;
            word_stb <= 1'b1;
        end
    end
endmodule // scanner_ctrl_model

// ### verif/cis_conv_properties.sv
// Port checker for the pixel conversion control block.
// Assumes conversion_clock holds each level for at least one clk.
module cis_conv_properties (
    input wire clk, rst_n, rd_en, conversion_clock, clamp, line_sync,
    input wire [7:0] rdata,
    input wire adc_sample_r, pga_track_next_r, adc_track_r, clamp_switch_r,
    input wire ext_ref_subtract_r, ref_out_enable_r, db_oe_n_r, serial_enable_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence fall_seen;
        $fell(conversion_clock);
    endsequence
    sequence pulse_once;
        adc_sample_r && pga_track_next_r ##1 !adc_sample_r;
    endsequence
    a_sample_on_fall: assert property (fall_seen |=> pulse_once)
        else $error("no sample pulse after fall");
    a_sample_only_fall: assert property (!$fell(conversion_clock) |=> !adc_sample_r)
        else $error("sample pulse without fall");
    a_track_follows: assert property (adc_track_r == $past(conversion_clock))
        else $error("track level off");
    a_clamp_cause: assert property (clamp_switch_r |-> $past(clamp))
        else $error("clamp switch without strobe");
    a_clamp_open: assert property ($fell(clamp) |=> !clamp_switch_r)
        else $error("clamp switch stays closed");
    a_bus_release: assert property ($past(line_sync) |-> db_oe_n_r && serial_enable_r)
        else $error("bus not released");
    a_bus_drive: assert property ($fell(line_sync) |=> !db_oe_n_r && !serial_enable_r)
        else $error("bus not driven");
    a_ref_excl: assert property (ext_ref_subtract_r |-> !ref_out_enable_r)
        else $error("reference pin both ways");
    a_read_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data outside read");
endmodule // cis_conv_properties
bind cis_pixel_conversion_control cis_conv_properties u_cis_conv_properties (
    .clk(clk), .rst_n(rst_n), .rd_en(rd_en), .conversion_clock(conversion_clock),
    .clamp(clamp), .line_sync(line_sync), .rdata(rdata), .adc_sample_r(adc_sample_r),
    .pga_track_next_r(pga_track_next_r), .adc_track_r(adc_track_r), .clamp_switch_r(clamp_switch_r),
    .ext_ref_subtract_r(ext_ref_subtract_r), .ref_out_enable_r(ref_out_enable_r),
    .db_oe_n_r(db_oe_n_r), .serial_enable_r(serial_enable_r));

// ### verif/testbench.sv
// Self-checking bench: register rows, modes, rotation, pixel stream.
// Assumes the scanner controller model drives the far-side pins.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, wr_en, rd_en, clamp, line_sync, run, conversion_clock, word_stb;
    logic adc_sample_r, adc_track_r, pga_track_next_r, clamp_switch_r, ext_ref_subtract_r;
    logic result_invert_r, ref_out_enable_r, db_oe_n_r, serial_enable_r;
    logic [3:0] addr;
    logic [5:0] pga_gain_r;
    logic [7:0] wdata, rdata, offset_dac_r, db_out_r, db_in, word_n, d;
    logic [15:0] adc_result, word;
    int n_fail, cmp_count;
    logic [3:0] ta [17] = '{1, 2, 3, 4, 5, 6, 8, 9, 15, 7, 0, 0, 0, 0, 0, 0, 0};
    logic [7:0] tw [17] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'ha6, 8'h2a, 8'hc3, 8'hff, 8'hff,
        8'h04, 8'h04, 8'h00, 8'h08, 8'h18, 8'h24, 8'h20};
    logic [7:0] tx [17] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'ha6, 8'h2a, 8'hc3, 8'h00, 8'h00,
        8'h04, 8'h04, 8'h00, 8'h08, 8'h18, 8'h24, 8'h20};
    logic tc [17] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 1, 0, 0, 1, 1};
    logic [3:0] tf [17] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8, 0, 0, 4, 2, 9, 0};
    logic [13:0] rot [4] = '{{6'h22, 8'h55}, {6'h33, 8'ha6}, {6'h11, 8'h44}, {6'h22, 8'h55}};
    cis_pixel_conversion_control u_cis_pixel_conversion_control (.clk(clk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .conversion_clock(conversion_clock), .clamp(clamp), .line_sync(line_sync),
        .adc_result(adc_result), .adc_sample_r(adc_sample_r), .adc_track_r(adc_track_r),
        .pga_track_next_r(pga_track_next_r), .clamp_switch_r(clamp_switch_r),
        .ext_ref_subtract_r(ext_ref_subtract_r), .offset_dac_r(offset_dac_r),
        .pga_gain_r(pga_gain_r), .result_invert_r(result_invert_r),
        .ref_out_enable_r(ref_out_enable_r), .db_out_r(db_out_r), .db_oe_n_r(db_oe_n_r),
        .db_in(db_in), .serial_enable_r(serial_enable_r));
    scanner_ctrl_model u_scanner_ctrl_model (.clk(clk), .run(run), .line_sync(line_sync),
        .adc_sample_r(adc_sample_r), .adc_track_r(adc_track_r), .db_out_r(db_out_r),
        .conversion_clock(conversion_clock), .adc_result(adc_result), .db_in(db_in),
        .word(word), .word_n(word_n), .word_stb(word_stb));
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Word seen n carries the pixel sampled eight falls before it
    always @(posedge clk) begin
        if (word_stb && word_n > 8'd8) check("word", word, {(word_n - 8'd8) ^ 8'h5a, word_n - 8'd8});
    end
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(50 * 5000);
        n_fail++;
        report_and_stop;
    end
    // ******************************
    // Main sequence
    // ******************************
    initial begin
        {rst_n, wr_en, rd_en, clamp, line_sync, run, addr, wdata} = '0;
        repeat (7) @(posedge clk);
        #1 check("reset", {db_oe_n_r, serial_enable_r, pga_gain_r, offset_dac_r}, 16'h8000);
        check("reset_sample", adc_sample_r, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        $display("test reset done");
        for (int i = 0; i < 17; i++) begin
            clamp <= tc[i];
            wr(ta[i], tw[i]);
            rd(ta[i], d);
            check("rdata", d, tx[i]);
            repeat (2) @(posedge clk);
            #1 check("flags", {clamp_switch_r, ext_ref_subtract_r, ref_out_enable_r, result_invert_r}, tf[i]);
            if (tw[i] == 8'h08) check("ofs", offset_dac_r, 8'hc3);
        end
        $display("test rows done");
        wr(0, 8'h03);
        for (int j = 0; j < 4; j++) begin
            line_sync <= 1'b1;
            repeat (3) @(posedge clk);
            #1 check("release", {db_oe_n_r, serial_enable_r}, 2'b11);
            line_sync <= 1'b0;
            repeat (3) @(posedge clk);
            #1 check("colour", {pga_gain_r, offset_dac_r}, rot[j]);
        end
        $display("test rotation done");
        wr(0, 8'h00);
        run <= 1'b1;
        for (int t = 0; t < 200 && word_n < 8'd20; t++) @(posedge clk);
        run <= 1'b0;
        check("words", word_n >= 8'd20, 1'b1);
        check("drive", db_oe_n_r, 1'b0);
        $display("test stream done");
        report_and_stop;
    end
endmodule // testbench
